//--- core/fpm_cmd_if.sv
// Flash programming mode entry, link selection and command interpreter
`timescale 1ns/1ps
module fpm_cmd_if
	import fpm_pkg::*;
#(
	parameter int PULSE_GAP = fpm_pkg::PULSE_GAP_CYC,
	parameter logic [7:0] SIG_CODE = 8'h5A // Arbitrary identification value
) (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic [3:0] wb_adr_i, // Register byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic wb_we_i, // Write strobe
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Slave select
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic vpp_level_i, // Programming-voltage pin at programming level
	input wire logic clocked_serial_clock_i, // Link clock from programmer
	input wire logic clocked_serial_in_i, // Serial data in
	output logic clocked_serial_out_o, // Serial data out
	input wire logic first_async_rx_i, // First async receive
	output logic first_async_tx_o, // First async transmit
	input wire logic second_async_rx_i, // Second async receive
	output logic second_async_tx_o, // Second async transmit
	output logic handshake_line_o, // Ready for a byte
	output logic prog_mode_o // Programming mode active
);
	import fpm_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] vpp_q, rx0_q, rx1_q;
	logic vpp_s, rx_s;
	fpm_link_e link_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vpp_q <= 2'h0;
			rx0_q <= 2'h3;
			rx1_q <= 2'h3;
		end else begin
			vpp_q <= {vpp_q[0], vpp_level_i};
			rx0_q <= {rx0_q[0], first_async_rx_i};
			rx1_q <= {rx1_q[0], second_async_rx_i};
		end
	end
	assign vpp_s = vpp_q[1];
	assign rx_s = (link_r == LNK_ASY1) ? rx1_q[1] : rx0_q[1];

	// ----------------------------------------------------------------
	// Mode entry and pulse counting
	// ----------------------------------------------------------------
	logic [1:0] strap_r;
	logic prog_r, vpp_d_r, sel_done_r;
	logic [3:0] pcnt_r;
	logic [31:0] gap_r;
	fpm_link_e link_dec;
	wire is_csi = (link_r == LNK_CSI) | (link_r == LNK_CSI_HS);
	wire is_asy = (link_r == LNK_ASY0) | (link_r == LNK_ASY1) | (link_r == LNK_ASY0_HS);
	wire is_hs = (link_r == LNK_CSI_HS) | (link_r == LNK_ASY0_HS);
	wire pulse_fall = vpp_d_r & ~vpp_s;
	always_comb begin
		case (pcnt_r)
			PULSES_CSI: link_dec = LNK_CSI;
			PULSES_CSI_HS: link_dec = LNK_CSI_HS;
			PULSES_ASY0: link_dec = LNK_ASY0;
			PULSES_ASY1: link_dec = LNK_ASY1;
			PULSES_ASY0_HS: link_dec = LNK_ASY0_HS;
			default: link_dec = LNK_NONE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_r <= 2'h0;
			prog_r <= 1'b0;
			vpp_d_r <= 1'b0;
			sel_done_r <= 1'b0;
			pcnt_r <= 4'h0;
			gap_r <= 32'h0;
			link_r <= LNK_NONE;
		end else begin
			vpp_d_r <= vpp_s;
			if (strap_r != 2'h3) begin
				strap_r <= strap_r + 2'h1;
				if (strap_r == 2'h2)
					prog_r <= vpp_s;
			end else if (prog_r && !sel_done_r) begin
				if (pulse_fall) begin
					gap_r <= 32'h0;
					if (pcnt_r != 4'hF)
						pcnt_r <= pcnt_r + 4'h1;
				end else if (gap_r >= PULSE_GAP && vpp_s) begin
					sel_done_r <= 1'b1;
					link_r <= link_dec;
				end else begin
					gap_r <= gap_r + 32'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Clocked serial link, link clock domain
	// ----------------------------------------------------------------
	logic [1:0] ltog_q;
	logic [2:0] lbit_r;
	logic [6:0] lsh_r, ltx_r;
	logic [7:0] lbyte_r, resp_dat_r;
	logic lrx_tog_r, lseen_r, lso_r, resp_tog_r;
	wire [7:0] lload = (ltog_q[1] != lseen_r) ? resp_dat_r : FLASH_ERASED;
	always_ff @(posedge clocked_serial_clock_i) begin
		ltog_q <= {ltog_q[0], resp_tog_r};
		// Link choice is settled before the first byte; a stopped link clock could not sync it
		if (!is_csi) begin
			lbit_r <= 3'h0;
			lsh_r <= 7'h0;
			ltx_r <= 7'h7F;
			lbyte_r <= 8'h0;
			lrx_tog_r <= 1'b0;
			lseen_r <= ltog_q[1];
			lso_r <= 1'b1;
		end else begin
			lbit_r <= lbit_r + 3'h1;
			lsh_r <= {lsh_r[5:0], clocked_serial_in_i};
			if (lbit_r == 3'h7) begin
				lbyte_r <= {lsh_r, clocked_serial_in_i};
				lrx_tog_r <= ~lrx_tog_r;
			end
			if (lbit_r == 3'h0) begin
				lso_r <= lload[7];
				ltx_r <= lload[6:0];
				lseen_r <= ltog_q[1];
			end else begin
				lso_r <= ltx_r[6];
				ltx_r <= {ltx_r[5:0], 1'b1};
			end
		end
	end
	assign clocked_serial_out_o = lso_r;

	// ----------------------------------------------------------------
	// Byte arrival from either link
	// ----------------------------------------------------------------
	logic [2:0] ctog_q;
	logic [15:0] div_r, ucnt_r;
	logic [3:0] ubit_r;
	logic [7:0] ush_r;
	logic ubusy_r, cal_r, cal_ev_r, uev_r;
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ctog_q <= 3'h0;
		else
			ctog_q <= {ctog_q[1:0], lrx_tog_r};
	end
	wire csi_ev = is_csi & (ctog_q[2] ^ ctog_q[1]);
	wire rx_ev = csi_ev | uev_r | cal_ev_r;
	wire [7:0] rx_byte = cal_ev_r ? CMD_RESET : (is_csi ? lbyte_r : ush_r);
	// Filler byte on the clocked link is skipped in ST_IDLE only; in ST_ARG and ST_DATA it is taken as data
	wire fill_byte = csi_ev & (rx_byte == 8'hFF);
	wire [31:0] cal_prod = 32'(ucnt_r) * CAL_MUL;

	// ----------------------------------------------------------------
	// Async receiver with bit-time calibration
	// ----------------------------------------------------------------
	logic baud_we;
	logic [7:0] baud_val;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= DIV_RST;
			ucnt_r <= 16'h0;
			ubit_r <= 4'h0;
			ush_r <= 8'h0;
			ubusy_r <= 1'b0;
			cal_r <= 1'b0;
			cal_ev_r <= 1'b0;
			uev_r <= 1'b0;
		end else begin
			cal_ev_r <= 1'b0;
			uev_r <= 1'b0;
			if (baud_we)
				div_r <= {3'h0, baud_val, 5'h0} << (BAUD_SHIFT - 5);
			if (!is_asy) begin
				ubusy_r <= 1'b0;
			end else if (!cal_r) begin
				if (!rx_s) begin
					ucnt_r <= ucnt_r + 16'h1;
				end else if (ucnt_r != 16'h0) begin
					div_r <= cal_prod[CAL_SHIFT +: 16];
					cal_r <= 1'b1;
					cal_ev_r <= 1'b1;
					ucnt_r <= 16'h0;
				end
			end else if (!ubusy_r) begin
				if (!rx_s) begin
					ubusy_r <= 1'b1;
					ubit_r <= 4'h0;
					ucnt_r <= {1'b0, div_r[15:1]};
				end
			end else if (ucnt_r != 16'h0) begin
				ucnt_r <= ucnt_r - 16'h1;
			end else begin
				ucnt_r <= div_r;
				ubit_r <= ubit_r + 4'h1;
				if (ubit_r == 4'h0 && rx_s)
					ubusy_r <= 1'b0;
				else if (ubit_r == 4'h9) begin
					ubusy_r <= 1'b0;
					uev_r <= 1'b1;
				end else if (ubit_r != 4'h0)
					ush_r <= {rx_s, ush_r[7:1]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Async transmitter
	// ----------------------------------------------------------------
	logic [9:0] tsh_r;
	logic [3:0] tbit_r;
	logic [15:0] tcnt_r;
	logic ttx_r, tx_load;
	logic [7:0] tx_byte;
	wire tx_idle = (tbit_r == 4'h0);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tsh_r <= 10'h3FF;
			tbit_r <= 4'h0;
			tcnt_r <= 16'h0;
			ttx_r <= 1'b1;
		end else if (tx_load) begin
			tsh_r <= {1'b1, tx_byte, 1'b0};
			tbit_r <= 4'hA;
			tcnt_r <= div_r;
		end else if (!tx_idle) begin
			ttx_r <= tsh_r[0];
			if (tcnt_r != 16'h0)
				tcnt_r <= tcnt_r - 16'h1;
			else begin
				tcnt_r <= div_r;
				tsh_r <= {1'b1, tsh_r[9:1]};
				tbit_r <= tbit_r - 4'h1;
			end
		end else begin
			ttx_r <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Flash array
	// ----------------------------------------------------------------
	logic [7:0] mem [0:(1 << FLASH_AW) - 1];
	logic [7:0] ptr_r, wbyte_r;
	logic mem_we;
	logic [7:0] mem_wd;
	wire [7:0] mem_rd = mem[ptr_r];
	always_ff @(posedge clk_i) begin
		if (mem_we)
			mem[ptr_r] <= mem_wd;
	end

	// ----------------------------------------------------------------
	// Command interpreter
	// ----------------------------------------------------------------
	fpm_state_e st_r;
	logic [7:0] cmd_r, cnt_r, freq_r, ert_r, wrt_r, resp_r, next_r;
	logic [15:0] tmr_r;
	logic arg_r, ok_r, wp_r;
	wire [15:0] erase_cyc = freq_r * ert_r;
	wire [15:0] write_cyc = freq_r * wrt_r;
	wire is_wr = (cmd_r == CMD_HSWR) | (cmd_r == CMD_SUCC);
	wire [7:0] status = {4'h0, ok_r, wp_r, cal_r, is_asy};
	assign baud_we = (st_r == ST_ARG) & rx_ev & (cmd_r == CMD_BAUD);
	assign baud_val = rx_byte;
	assign mem_we = ((st_r == ST_WAIT) & (tmr_r == 16'h0) & is_wr) | ((st_r == ST_WALK) & (cmd_r == CMD_ERASE));
	assign mem_wd = (st_r == ST_WALK) ? FLASH_ERASED : wbyte_r;
	assign tx_load = (st_r == ST_RESP) & is_asy & tx_idle;
	assign tx_byte = resp_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= ST_IDLE;
			cmd_r <= CMD_RESET;
			{cnt_r, ptr_r, wbyte_r, resp_r, next_r} <= 40'h0;
			freq_r <= FREQ_RST;
			ert_r <= ERT_RST;
			wrt_r <= WRT_RST;
			tmr_r <= 16'h0;
			{arg_r, ok_r} <= 2'h0;
			resp_tog_r <= 1'b0;
			resp_dat_r <= FLASH_ERASED;
		end else begin
			case (st_r)
				ST_IDLE: if (rx_ev && !fill_byte) begin
					cmd_r <= rx_byte;
					ok_r <= 1'b1;
					ptr_r <= 8'h0;
					arg_r <= 1'b0;
					st_r <= ST_ARG;
					case (rx_byte)
						CMD_RESET: begin
							resp_r <= RSP_ACK;
							st_r <= ST_RESP;
						end
						CMD_VERIFY: st_r <= ST_DATA;
						CMD_ERASE: begin
							tmr_r <= erase_cyc;
							resp_r <= RSP_NAK;
							st_r <= wp_r ? ST_RESP : ST_WAIT;
						end
						CMD_BLANK: st_r <= ST_WALK;
						CMD_SUCC: begin
							ptr_r <= next_r;
							arg_r <= 1'b1;
						end
						CMD_STAT: begin
							resp_r <= status;
							st_r <= ST_RESP;
						end
						CMD_SIG: begin
							resp_r <= SIG_CODE;
							st_r <= ST_RESP;
						end
						CMD_HSWR, CMD_OSC, CMD_ERT, CMD_WRT: st_r <= ST_ARG;
						CMD_BAUD: begin
							resp_r <= RSP_NAK;
							st_r <= is_asy ? ST_ARG : ST_RESP;
						end
						default: begin
							resp_r <= RSP_NAK;
							st_r <= ST_RESP;
						end
					endcase
				end
				ST_ARG: if (rx_ev) begin
					resp_r <= RSP_ACK;
					st_r <= ST_RESP;
					if (rx_byte == CMD_RESET && !(is_wr && arg_r)) begin
						resp_r <= RSP_ACK;
					end else if (is_wr && !arg_r) begin
						ptr_r <= rx_byte;
						arg_r <= 1'b1;
						st_r <= ST_ARG;
					end else if (is_wr) begin
						cnt_r <= rx_byte;
						resp_r <= RSP_NAK;
						st_r <= (wp_r || rx_byte == 8'h0) ? ST_RESP : ST_DATA;
					end else if (cmd_r == CMD_OSC)
						freq_r <= rx_byte;
					else if (cmd_r == CMD_ERT)
						ert_r <= rx_byte;
					else if (cmd_r == CMD_WRT)
						wrt_r <= rx_byte;
				end
				ST_DATA: if (rx_ev) begin
					if (is_wr) begin
						wbyte_r <= rx_byte;
						tmr_r <= write_cyc;
						st_r <= ST_WAIT;
					end else begin
						ok_r <= ok_r & (mem_rd == rx_byte);
						ptr_r <= ptr_r + 8'h1;
						if (ptr_r == PTR_LAST) begin
							resp_r <= (ok_r && mem_rd == rx_byte) ? RSP_ACK : RSP_NAK;
							st_r <= ST_RESP;
						end
					end
				end
				ST_WAIT: if (rx_ev && rx_byte == CMD_RESET) begin
					resp_r <= RSP_ACK;
					st_r <= ST_RESP;
				end else if (tmr_r != 16'h0)
					tmr_r <= tmr_r - 16'h1;
				else
					st_r <= is_wr ? ST_CHECK : ST_WALK;
				ST_CHECK: begin
					ok_r <= ok_r & (mem_rd == wbyte_r);
					ptr_r <= ptr_r + 8'h1;
					cnt_r <= cnt_r - 8'h1;
					st_r <= ST_DATA;
					if (cnt_r == 8'h1) begin
						next_r <= ptr_r + 8'h1;
						resp_r <= (ok_r && mem_rd == wbyte_r) ? RSP_ACK : RSP_NAK;
						st_r <= ST_RESP;
					end
				end
				ST_WALK: begin
					if (cmd_r == CMD_BLANK)
						ok_r <= ok_r & (mem_rd == FLASH_ERASED);
					ptr_r <= ptr_r + 8'h1;
					if (ptr_r == PTR_LAST) begin
						resp_r <= (cmd_r == CMD_ERASE || (ok_r && mem_rd == FLASH_ERASED)) ? RSP_ACK : RSP_NAK;
						st_r <= ST_RESP;
					end
				end
				ST_RESP: if (is_csi) begin
					resp_dat_r <= resp_r;
					resp_tog_r <= ~resp_tog_r;
					st_r <= ST_IDLE;
				end else if (tx_idle)
					st_r <= ST_IDLE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs and register bus
	// ----------------------------------------------------------------
	logic hs_r, prog_o_r, tx0_r, tx1_r, ack_r;
	logic [31:0] rdat_r;
	wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
	wire ready = (st_r == ST_IDLE) | (st_r == ST_ARG) | (st_r == ST_DATA);
	wire [31:0] rd_mux = (wb_adr_i == ADR_CTRL) ? {31'h0, wp_r} :
		(wb_adr_i == ADR_STAT) ? {18'h0, link_r, st_r, prog_r} :
		(wb_adr_i == ADR_TIME) ? {8'h0, freq_r, ert_r, wrt_r} :
		(wb_adr_i == ADR_DIV) ? {16'h0, div_r} : 32'h0;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{hs_r, prog_o_r, ack_r, wp_r} <= 4'h0;
			{tx0_r, tx1_r} <= 2'h3;
			rdat_r <= 32'h0;
		end else begin
			hs_r <= is_hs & ready;
			prog_o_r <= prog_r;
			tx0_r <= (link_r == LNK_ASY1) | ttx_r;
			tx1_r <= (link_r != LNK_ASY1) | ttx_r;
			ack_r <= bus_req;
			rdat_r <= bus_req ? rd_mux : 32'h0;
			if (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
				wp_r <= wb_dat_i[CTRL_WP_BIT];
		end
	end
	assign handshake_line_o = hs_r;
	assign prog_mode_o = prog_o_r;
	assign first_async_tx_o = tx0_r;
	assign second_async_tx_o = tx1_r;
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
endmodule

//--- core/fpm_pkg.sv
// Constants, codes and types shared by the flash programming command interface
package fpm_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STAT = 4'h4;
	localparam logic [3:0] ADR_TIME = 4'h8;
	localparam logic [3:0] ADR_DIV = 4'hC;
	localparam int CTRL_WP_BIT = 0;
	// ----------------------------------------------------------------
	// Command and response codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] CMD_VERIFY = 8'h13;
	localparam logic [7:0] CMD_ERASE = 8'h20;
	localparam logic [7:0] CMD_BLANK = 8'h32;
	localparam logic [7:0] CMD_HSWR = 8'h40;
	localparam logic [7:0] CMD_SUCC = 8'h44;
	localparam logic [7:0] CMD_STAT = 8'h70;
	localparam logic [7:0] CMD_OSC = 8'h90;
	localparam logic [7:0] CMD_ERT = 8'h95;
	localparam logic [7:0] CMD_BAUD = 8'h9A;
	localparam logic [7:0] CMD_WRT = 8'hA0;
	localparam logic [7:0] CMD_SIG = 8'hC0;
	localparam logic [7:0] RSP_ACK = 8'h06;
	localparam logic [7:0] RSP_NAK = 8'h15;
	// ----------------------------------------------------------------
	// Link selection by pulse count
	// ----------------------------------------------------------------
	localparam logic [3:0] PULSES_CSI = 4'h0;
	localparam logic [3:0] PULSES_CSI_HS = 4'h3;
	localparam logic [3:0] PULSES_ASY0 = 4'h8;
	localparam logic [3:0] PULSES_ASY1 = 4'h9;
	localparam logic [3:0] PULSES_ASY0_HS = 4'hB;
	localparam logic [3:0] PULSES_MAX = 4'hB;
	// ----------------------------------------------------------------
	// Timing and reset values
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50000000;
	localparam int PULSE_GAP_US = 1000;
	localparam int PULSE_GAP_CYC = PULSE_GAP_US * (CLK_HZ / 1000000);
	localparam logic [7:0] FREQ_RST = 8'h0A;
	localparam logic [7:0] ERT_RST = 8'h01;
	localparam logic [7:0] WRT_RST = 8'h01;
	localparam logic [15:0] DIV_RST = 16'h1458;
	localparam int CAL_MUL = 57;
	localparam int CAL_SHIFT = 9;
	localparam int BAUD_SHIFT = 5;
	localparam int FLASH_AW = 8;
	localparam logic [7:0] FLASH_ERASED = 8'hFF;
	localparam logic [7:0] PTR_LAST = 8'hFF;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		LNK_NONE = 6'h01,
		LNK_CSI = 6'h02,
		LNK_CSI_HS = 6'h04,
		LNK_ASY0 = 6'h08,
		LNK_ASY1 = 6'h10,
		LNK_ASY0_HS = 6'h20
	} fpm_link_e;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ARG = 7'h02,
		ST_DATA = 7'h04,
		ST_WAIT = 7'h08,
		ST_WALK = 7'h10,
		ST_CHECK = 7'h20,
		ST_RESP = 7'h40
	} fpm_state_e;
endpackage

//--- verification/fpm_cmd_if_asserts.sv
// Port-level checker for the flash programming command interface
`timescale 1ns/1ps
module fpm_cmd_if_asserts (
	input wire logic clk_i, // System clock
	input wire logic rst_i, // Synchronous reset
	input wire logic [3:0] wb_adr_i, // Register address
	input wire logic wb_we_i, // Write strobe
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Slave select
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Acknowledge
	input wire logic vpp_level_i, // Programming level
	input wire logic first_async_tx_o, // First async transmit
	input wire logic second_async_tx_o, // Second async transmit
	input wire logic handshake_line_o, // Ready level
	input wire logic prog_mode_o // Programming mode
);
	wire req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire mapped_w = wb_adr_i inside {4'h0, 4'h4, 4'h8, 4'hC};
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ----------------------------------------------------------------
	// Bus and mode relations
	// ----------------------------------------------------------------
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_latency_a: assert property (req_w |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	data_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	unmapped_zero_a: assert property (req_w && !wb_we_i && !mapped_w |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	hs_mode_a: assert property (!prog_mode_o |-> !handshake_line_o)
		else $error("handshake outside programming mode");
	mode_hold_a: assert property (prog_mode_o |=> prog_mode_o)
		else $error("programming mode dropped");
	mode_strap_a: assert property ($rose(prog_mode_o) |-> vpp_level_i)
		else $error("mode entered with pin low");
	mode_entry_a: assert property ($fell(rst_i) && vpp_level_i |-> ##[1:8] prog_mode_o)
		else $error("mode not entered");
	tx_idle_a: assert property (!prog_mode_o |-> first_async_tx_o && second_async_tx_o)
		else $error("tx moved in normal mode");
	cover property (wb_ack_o && !wb_we_i);
	cover property ($rose(prog_mode_o));
	cover property ($rose(handshake_line_o));
endmodule
bind fpm_cmd_if fpm_cmd_if_asserts u_chk (.clk_i, .rst_i, .wb_adr_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
	.wb_ack_o, .vpp_level_i, .first_async_tx_o, .second_async_tx_o, .handshake_line_o, .prog_mode_o);

//--- verification/fpm_prog_model.sv
// Behavioural flash programmer on the far side of the link
`timescale 1ns/1ps
module fpm_prog_model (
	input wire logic clk_i, // System clock for pulse timing
	input wire logic sdo_i, // Device serial out
	input wire logic hs_i, // Device ready level
	output logic vpp_o, // Programming level
	output logic sck_o, // Link clock, still between bytes
	output logic sdi_o, // Serial data to device
	output logic rx0_o, // First async line, idle
	output logic rx1_o // Second async line, idle
);
	initial begin
		vpp_o = 1'b0;
		sck_o = 1'b0;
		sdi_o = 1'b1;
		rx0_o = 1'b1;
		rx1_o = 1'b1;
	end
	task automatic set_vpp(input logic lvl);
		@(posedge clk_i);
		vpp_o <= lvl;
	endtask
	// Low dips, never more than eleven
	task automatic pulses(input int n);
		for (int i = 0; i < n && i < 11; i++) begin
			repeat (5) @(posedge clk_i);
			vpp_o <= 1'b0;
			repeat (5) @(posedge clk_i);
			vpp_o <= 1'b1;
		end
	endtask
	// One byte each way, MSB first; released line shows inverse
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		repeat (8) @(posedge clk_i);
		for (int w = 0; w < 64 && hs_i !== 1'b1; w++) @(posedge clk_i);
		for (int i = 7; i >= 0; i--) begin
			sdi_o = tx[i];
			#16;
			sck_o = 1'b1;
			#16;
			rx[i] = sdo_i;
			sck_o = 1'b0;
		end
		sdi_o = ~tx[0];
	endtask
	// Async frame on one receive line, LSB first
	task automatic uart_send(input logic ch, input logic [7:0] v, input int bt);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			if (ch)
				rx1_o <= f[i];
			else
				rx0_o <= f[i];
			repeat (bt - 1) @(posedge clk_i);
		end
	endtask
endmodule

//--- verification/tb_fpm_cmd_if.sv
// Self-checking bench: link selection, registers and programmer commands
`timescale 1ns/1ps
module tb_fpm_cmd_if;
	import fpm_pkg::*;
	localparam int GAP = 200;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [3:0] wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, vpp, sck, sdi, rx0, rx1, sdo, tx0, tx1, hs, prog_mode;
	logic [3:0] pc [6] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'hB, 4'h5};
	fpm_link_e lk [6] = '{LNK_CSI, LNK_CSI_HS, LNK_ASY0, LNK_ASY1, LNK_ASY0_HS, LNK_NONE};
	int miscompares = 0;
	int n_checks = 0;
	logic [31:0] rd;
	logic [7:0] r8;
	always #10 clk_i = ~clk_i;
	fpm_cmd_if #(.PULSE_GAP(GAP), .SIG_CODE(8'h3C)) dut ( // Signature value arbitrary
		.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.vpp_level_i(vpp), .clocked_serial_clock_i(sck), .clocked_serial_in_i(sdi), .clocked_serial_out_o(sdo),
		.first_async_rx_i(rx0), .first_async_tx_o(tx0), .second_async_rx_i(rx1), .second_async_tx_o(tx1),
		.handshake_line_o(hs), .prog_mode_o(prog_mode));
	fpm_prog_model prog (.clk_i(clk_i), .sdo_i(sdo), .hs_i(hs), .vpp_o(vpp), .sck_o(sck), .sdi_o(sdi),
		.rx0_o(rx0), .rx1_o(rx1));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
		int t;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		wb_sel_i <= 4'hF;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		q = wb_dat_o;
		if (t >= 50) miscompares++;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic start(input logic lvl, input int n);
		int t;
		rst_i <= 1'b1;
		prog.set_vpp(lvl);
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t = 0;
		while (prog_mode !== 1'b1 && t < 20) begin
			@(posedge clk_i);
			t++;
		end
		check("prog_mode", prog_mode, lvl);
		prog.pulses(n);
		repeat (GAP + 20) @(posedge clk_i);
	endtask
	task automatic send(input logic [7:0] v);
		logic [7:0] junk;
		prog.xfer(v, junk);
	endtask
	// Async response frame, LSB first, 64-cycle bits
	task automatic urx(input logic ch, output logic [7:0] v);
		int t;
		t = 0;
		while ((ch ? tx1 : tx0) !== 1'b0 && t < 4000) begin
			@(posedge clk_i);
			t++;
		end
		repeat (96) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			v[i] = ch ? tx1 : tx0;
			check("tx_other", ch ? tx0 : tx1, 32'h1);
			repeat (64) @(posedge clk_i);
		end
	endtask
	// Poll with idle bytes until a response byte shows
	task automatic resp(input string what, input logic [7:0] exp, input logic [7:0] m);
		logic [7:0] r;
		r = 8'hFF;
		for (int t = 0; t < 40 && r === 8'hFF; t++) prog.xfer(8'hFF, r);
		check(what, r & m, exp);
	endtask
	task automatic cmd(input string what, input logic [7:0] c, input int na, input logic [7:0] a, input logic [7:0] exp);
		send(c);
		if (na > 0) send(a);
		resp(what, exp, 8'hFF);
	endtask
	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		start(1'b0, 0);
		for (int i = 0; i < 6; i++) begin
			start(1'b1, int'(pc[i]));
			wb(1'b0, ADR_STAT, 32'h0, rd);
			check("link", {rd[13:8], rd[0]}, {lk[i], 1'b1});
			if (i == 2 || i == 3) begin
				fork
					prog.uart_send(i == 3, CMD_RESET, 64);
					urx(i == 3, r8);
				join
				check("cal_ack", r8, RSP_ACK);
			end
		end
		send(CMD_STAT);
		resp("ignored", 8'hFF, 8'hFF);
		start(1'b1, 3);
		wb(1'b0, ADR_TIME, 32'h0, rd);
		check("time_rst", rd, {8'h00, FREQ_RST, ERT_RST, WRT_RST});
		wb(1'b0, ADR_DIV, 32'h0, rd);
		check("div_rst", rd, {16'h0, DIV_RST});
		wb(1'b1, ADR_TIME, 32'h00FFFFFF, rd);
		wb(1'b0, ADR_TIME, 32'h0, rd);
		check("time_ro", rd, {8'h00, FREQ_RST, ERT_RST, WRT_RST});
		wb(1'b0, 4'h2, 32'h0, rd);
		check("unmapped", rd, 32'h0);
		cmd("reset", CMD_RESET, 0, 8'h00, RSP_ACK);
		cmd("sig", CMD_SIG, 0, 8'h00, 8'h3C);
		cmd("unknown", 8'h55, 0, 8'h00, RSP_NAK);
		cmd("baud_csi", CMD_BAUD, 0, 8'h00, RSP_NAK);
		cmd("osc", CMD_OSC, 1, 8'h0C, RSP_ACK);
		cmd("ert", CMD_ERT, 1, 8'h02, RSP_ACK);
		cmd("wrt", CMD_WRT, 1, 8'h03, RSP_ACK);
		cmd("abort", CMD_OSC, 1, 8'h00, RSP_ACK);
		wb(1'b0, ADR_TIME, 32'h0, rd);
		check("time_set", rd, 32'h000C0203);
		wb(1'b1, ADR_CTRL, 32'h1, rd);
		cmd("erase_wp", CMD_ERASE, 0, 8'h00, RSP_NAK);
		send(CMD_STAT);
		resp("status", 8'h04, 8'h05);
		wb(1'b1, ADR_CTRL, 32'h0, rd);
		cmd("erase", CMD_ERASE, 0, 8'h00, RSP_ACK);
		cmd("blank", CMD_BLANK, 0, 8'h00, RSP_ACK);
		send(CMD_HSWR);
		cmd("hsw_zero", 8'h10, 1, 8'h00, RSP_NAK);
		send(CMD_HSWR);
		send(8'h10);
		send(8'h02);
		send(8'hA5);
		cmd("hsw", 8'h3C, 0, 8'h00, RSP_ACK);
		send(CMD_SUCC);
		cmd("succ", 8'h01, 1, 8'h77, RSP_ACK);
		cmd("blank_used", CMD_BLANK, 0, 8'h00, RSP_NAK);
		for (int k = 0; k < 2; k++) begin
			send(CMD_VERIFY);
			for (int a = 0; a < 256; a++) begin
				send((k == 1) ? 8'hFF : (a == 16) ? 8'hA5 : (a == 17) ? 8'h3C : (a == 18) ? 8'h77 : 8'hFF);
			end
			resp("verify", (k == 1) ? RSP_NAK : RSP_ACK, 8'hFF);
		end
		complete_run();
	end
	initial begin
		repeat (100000) @(posedge clk_i);
		miscompares++;
		complete_run();
	end
endmodule
